// file: rtl/program_space_table_access.sv
// What this block does
// - program word steps data address by two
// - word low read returns bits fifteen down
// - byte low read picks byte by select
// - word high read zeroes phantom upper byte
// - byte high read of phantom returns zero
// - page top bit selects configuration space
// - target address is page plus effective address
// - low ops reach low sixteen bits
// - high ops reach upper eight bits
// - rows of sixty four, pages of 512
// - table ops only in normal mode
// - table write fills buffers in two cycles
`timescale 1ns/100ps
module program_space_table_access
    import table_access_pkg::*;
#(
    parameter int unsigned HOLD_DEPTH = table_access_pkg::ROW_WORDS
) (
    input wire logic clk_i, // core clock
    input wire logic rst_i, // synchronous reset, high
    input wire logic [table_access_pkg::ADR_W-1:0] adr_i, // wishbone byte address
    input wire logic [31:0] dat_i, // wishbone write data
    output logic [31:0] dat_o, // wishbone read data
    input wire logic we_i, // wishbone write
    input wire logic [3:0] sel_i, // wishbone byte lanes
    input wire logic cyc_i, // wishbone cycle
    input wire logic stb_i, // wishbone strobe
    output logic ack_o, // wishbone acknowledge
    input wire logic run_mode_i, // normal operating mode
    output logic prog_rd_o, // array read strobe
    output logic [table_access_pkg::WORD_W-1:0] prog_addr_o, // array target address
    input wire logic [table_access_pkg::WORD_W-1:0] prog_rdata_i, // array data, next cycle
    output logic cfg_space_o, // page points at config space
    output logic busy_o, // table operation running
    input wire logic [$clog2(HOLD_DEPTH)-1:0] hold_idx_i, // buffer entry to read
    output logic [table_access_pkg::WORD_W-1:0] hold_data_o, // buffer entry, next cycle
    output logic [16:0] hold_row_o, // row of last buffered write
    output logic [table_access_pkg::COUNT_W-1:0] hold_count_o, // low writes buffered
    input wire logic hold_clear_i // programming cycle consumed buffers
);
    import table_access_pkg::*;

    localparam int unsigned IDX_W = $clog2(HOLD_DEPTH);
    localparam logic [COUNT_W-1:0] COUNT_MAX = COUNT_W'(HOLD_DEPTH);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        table_state_e state;
        logic [PAGE_W-1:0] page;
        logic [OPERAND_ADDR_W-1:0] operand_effective_address;
        logic [DATA_W-1:0] data;
        logic high;
        logic is_wr;
        logic byte_mode;
        logic inc;
        logic err;
        logic ack;
        logic [31:0] rdat;
        logic prog_rd;
        logic [WORD_W-1:0] prog_addr;
        logic [WORD_W-1:0] wr_word;
        logic [16:0] row;
        logic [COUNT_W-1:0] count;
        logic busy;
        logic cfg;
    } regs_s;

    regs_s cur_ff;
    regs_s nxt_cur;
    logic [WORD_W-1:0] hold_mem [HOLD_DEPTH];
    logic [WORD_W-1:0] hold_data_ff;
    logic [DATA_W-1:0] mapped;
    logic [WORD_W-1:0] old_word;
    logic [IDX_W-1:0] cur_idx;
    logic bus_req;
    logic idle;
    logic [COUNT_W-1:0] count_base;

    ////////////////////////////////////////////////////////////////////////////////
    // read data steering

    table_read_mapper u_mapper (
        .prog_word_i(prog_rdata_i),
        .high_i(cur_ff.high),
        .byte_mode_i(cur_ff.byte_mode),
        .byte_sel_i(cur_ff.operand_effective_address[0]),
        .data_o(mapped)
    );

    // holding entry addressed by the word part of the effective address
    assign cur_idx = cur_ff.operand_effective_address[IDX_W:1];
    assign old_word = hold_mem[cur_idx];
    assign bus_req = cyc_i && stb_i && !cur_ff.ack;
    assign idle = (cur_ff.state == ST_IDLE);

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.ack = bus_req;
        nxt_cur.prog_rd = 1'b0;
        count_base = hold_clear_i ? '0 : cur_ff.count;
        nxt_cur.count = count_base;

        // register reads, sampled at the request edge
        if (bus_req) begin
            nxt_cur.rdat = 32'h0000_0000;
            unique case (adr_i)
                OFF_PAGE: nxt_cur.rdat = {24'h00_0000, cur_ff.page};
                OFF_OPERAND_ADDR: nxt_cur.rdat = {16'h0000, cur_ff.operand_effective_address};
                OFF_DATA: nxt_cur.rdat = {16'h0000, cur_ff.data};
                OFF_CMD: nxt_cur.rdat = {28'h000_0000, cur_ff.inc, cur_ff.byte_mode,
                                         cur_ff.is_wr, cur_ff.high};
                OFF_STATUS: begin
                    nxt_cur.rdat[STAT_BUSY_BIT] = cur_ff.busy;
                    nxt_cur.rdat[STAT_ERR_BIT] = cur_ff.err;
                    nxt_cur.rdat[STAT_CFG_BIT] = cur_ff.cfg;
                    nxt_cur.rdat[STAT_COUNT_LSB +: COUNT_W] = cur_ff.count;
                end
                default: nxt_cur.rdat = 32'h0000_0000;
            endcase
        end

        // register writes; anything but status is refused while busy
        if (bus_req && we_i) begin
            if (adr_i == OFF_STATUS) begin
                // write one clears the error flag
                if (sel_i[0] && dat_i[STAT_ERR_BIT]) begin
                    nxt_cur.err = 1'b0;
                end
            end else if (!idle) begin
                if (adr_i == OFF_PAGE || adr_i == OFF_OPERAND_ADDR || adr_i == OFF_DATA ||
                    adr_i == OFF_CMD) begin
                    nxt_cur.err = 1'b1;
                end
            end else begin
                unique case (adr_i)
                    OFF_PAGE: begin
                        if (sel_i[0]) begin
                            nxt_cur.page = dat_i[7:0];
                        end
                    end
                    OFF_OPERAND_ADDR: begin
                        if (sel_i[0]) begin
                            nxt_cur.operand_effective_address[7:0] = dat_i[7:0];
                        end
                        if (sel_i[1]) begin
                            nxt_cur.operand_effective_address[15:8] = dat_i[15:8];
                        end
                    end
                    OFF_DATA: begin
                        if (sel_i[0]) begin
                            nxt_cur.data[7:0] = dat_i[7:0];
                        end
                        if (sel_i[1]) begin
                            nxt_cur.data[15:8] = dat_i[15:8];
                        end
                    end
                    OFF_CMD: begin
                        if (!sel_i[0] || !run_mode_i) begin
                            nxt_cur.err = 1'b1;
                        end else begin
                            nxt_cur.high = dat_i[CMD_HIGH_BIT];
                            nxt_cur.is_wr = dat_i[CMD_WRITE_BIT];
                            nxt_cur.byte_mode = dat_i[CMD_BYTE_BIT];
                            nxt_cur.inc = dat_i[CMD_INC_BIT];
                            if (dat_i[CMD_WRITE_BIT]) begin
                                nxt_cur.state = ST_WR_MERGE;
                            end else begin
                                nxt_cur.prog_rd = 1'b1;
                                nxt_cur.prog_addr = {cur_ff.page,
                                                     cur_ff.operand_effective_address};
                                nxt_cur.state = ST_RD_REQ;
                            end
                        end
                    end
                    default: nxt_cur.err = cur_ff.err;
                endcase
            end
        end

        // table operation sequencer
        unique case (cur_ff.state)
            ST_IDLE: begin
            end
            ST_RD_REQ: begin
                // the array answers one cycle after the strobe
                nxt_cur.state = ST_RD_CAP;
            end
            ST_RD_CAP: begin
                nxt_cur.data = mapped;
                if (cur_ff.inc) begin
                    nxt_cur.operand_effective_address = cur_ff.operand_effective_address +
                        (cur_ff.byte_mode ? BYTE_STEP : WORD_STEP);
                end
                nxt_cur.state = ST_IDLE;
            end
            ST_WR_MERGE: begin
                nxt_cur.wr_word = old_word;
                if (!cur_ff.high) begin
                    // low ops touch bits fifteen down
                    if (!cur_ff.byte_mode) begin
                        nxt_cur.wr_word[15:0] = cur_ff.data;
                    end else if (cur_ff.operand_effective_address[0]) begin
                        nxt_cur.wr_word[15:8] = cur_ff.data[7:0];
                    end else begin
                        nxt_cur.wr_word[7:0] = cur_ff.data[7:0];
                    end
                end else if (!cur_ff.byte_mode || !cur_ff.operand_effective_address[0]) begin
                    // high ops touch upper byte only
                    nxt_cur.wr_word[23:16] = cur_ff.data[7:0];
                end
                nxt_cur.state = ST_WR_COMMIT;
            end
            ST_WR_COMMIT: begin
                // second cycle lands in the buffer
                nxt_cur.row = {cur_ff.page, cur_ff.operand_effective_address[15:ROW_LSB]};
                // one row of buffered words at most
                if (!cur_ff.high && count_base < COUNT_MAX) begin
                    nxt_cur.count = count_base + 1'b1;
                end
                if (cur_ff.inc) begin
                    nxt_cur.operand_effective_address = cur_ff.operand_effective_address +
                        (cur_ff.byte_mode ? BYTE_STEP : WORD_STEP);
                end
                nxt_cur.state = ST_IDLE;
            end
        endcase

        nxt_cur.busy = (nxt_cur.state != ST_IDLE);
        // top page bit picks configuration space
        nxt_cur.cfg = nxt_cur.page[CFG_PAGE_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    // one register bank for all control state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_ff <= '0;
            cur_ff.state <= ST_IDLE;
            cur_ff.page <= PAGE_RST;
            cur_ff.operand_effective_address <= OPERAND_ADDR_RST;
            cur_ff.data <= DATA_RST;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // holding buffers only; the array changes in a separate programming cycle
    always_ff @(posedge clk_i) begin
        if (cur_ff.state == ST_WR_COMMIT) begin
            hold_mem[cur_idx] <= cur_ff.wr_word;
        end
        hold_data_ff <= hold_mem[hold_idx_i];
    end

    assign dat_o = cur_ff.rdat;
    assign ack_o = cur_ff.ack;
    assign prog_rd_o = cur_ff.prog_rd;
    assign prog_addr_o = cur_ff.prog_addr;
    assign cfg_space_o = cur_ff.cfg;
    assign busy_o = cur_ff.busy;
    assign hold_data_o = hold_data_ff;
    assign hold_row_o = cur_ff.row;
    assign hold_count_o = cur_ff.count;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_read_steps;
        cur_ff.state == ST_RD_REQ ##1 cur_ff.state == ST_RD_CAP ##1 cur_ff.state == ST_IDLE;
    endsequence

    sequence s_write_steps;
        cur_ff.state == ST_WR_COMMIT ##1 cur_ff.state == ST_IDLE;
    endsequence

    a_write_two_cycles: assert property (
        cur_ff.state == ST_WR_MERGE |=> s_write_steps)
        else $error("table write did not finish in two cycles");

    a_read_target_addr: assert property (
        prog_rd_o |-> prog_addr_o == {$past(cur_ff.page),
                                      $past(cur_ff.operand_effective_address)} ##0 s_read_steps)
        else $error("read target address or read sequence wrong");

    a_low_word_read: assert property (
        cur_ff.state == ST_RD_CAP && !cur_ff.high && !cur_ff.byte_mode
        |=> cur_ff.data == $past(prog_rdata_i[15:0]))
        else $error("low word read does not return low program bits");

    a_low_byte_read: assert property (
        cur_ff.state == ST_RD_CAP && !cur_ff.high && cur_ff.byte_mode
        |=> cur_ff.data == {8'h00, $past(cur_ff.operand_effective_address[0])
                                   ? $past(prog_rdata_i[15:8]) : $past(prog_rdata_i[7:0])})
        else $error("low byte read picked wrong byte");

    a_high_phantom_zero: assert property (
        cur_ff.state == ST_RD_CAP && cur_ff.high
        |=> cur_ff.data[15:8] == 8'h00)
        else $error("phantom byte not zero");

    a_high_byte_phantom: assert property (
        cur_ff.state == ST_RD_CAP && cur_ff.high && cur_ff.byte_mode
        && cur_ff.operand_effective_address[0]
        |=> cur_ff.data == 16'h0000)
        else $error("phantom byte select did not read zero");

    a_word_step_two: assert property (
        cur_ff.state == ST_RD_CAP && cur_ff.inc && !cur_ff.byte_mode
        |=> cur_ff.operand_effective_address
            == $past(cur_ff.operand_effective_address) + WORD_STEP)
        else $error("word access did not advance address by two");

    a_refused_off_mode: assert property (
        idle && !run_mode_i |=> cur_ff.state == ST_IDLE)
        else $error("table operation started outside normal mode");

    a_cfg_follows_page: assert property (
        bus_req && we_i && idle && adr_i == OFF_PAGE && sel_i[0]
        |=> cfg_space_o == $past(dat_i[CFG_PAGE_BIT]) && cur_ff.page == $past(dat_i[7:0]))
        else $error("page write not seen at once");

    a_count_bounded: assert property (
        hold_count_o <= COUNT_MAX)
        else $error("buffer count beyond one row");

    a_ack_single: assert property (
        ack_o |=> !ack_o)
        else $error("acknowledge held more than one cycle");

endmodule

// file: rtl/table_access_pkg.sv
package table_access_pkg;

    // widths of the program and data sides
    localparam int unsigned PAGE_W = 8;
    localparam int unsigned OPERAND_ADDR_W = 16;
    localparam int unsigned WORD_W = 24;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADR_W = 8;

    // register byte offsets on the wishbone slave
    localparam logic [7:0] OFF_PAGE = 8'h00;
    localparam logic [7:0] OFF_OPERAND_ADDR = 8'h04;
    localparam logic [7:0] OFF_DATA = 8'h08;
    localparam logic [7:0] OFF_CMD = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;

    // command register field positions
    localparam int unsigned CMD_HIGH_BIT = 0;
    localparam int unsigned CMD_WRITE_BIT = 1;
    localparam int unsigned CMD_BYTE_BIT = 2;
    localparam int unsigned CMD_INC_BIT = 3;

    // status register field positions
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_ERR_BIT = 1;
    localparam int unsigned STAT_CFG_BIT = 2;
    localparam int unsigned STAT_COUNT_LSB = 8;

    // page bit that selects configuration space
    localparam int unsigned CFG_PAGE_BIT = 7;

    // array geometry
    localparam int unsigned ROW_WORDS = 64;
    localparam int unsigned ROW_BYTES = 192;
    localparam int unsigned PAGE_WORDS = 512;
    localparam int unsigned PAGE_BYTES = 1536;
    localparam int unsigned ROW_LSB = 7;
    localparam int unsigned COUNT_W = 7;

    // address steps: one program word spans two data addresses
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [15:0] BYTE_STEP = 16'h0001;

    // values after reset
    localparam logic [7:0] PAGE_RST = 8'h00;
    localparam logic [15:0] OPERAND_ADDR_RST = 16'h0000;
    localparam logic [15:0] DATA_RST = 16'h0000;

    // sequencer states
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RD_REQ = 5'b00010,
        ST_RD_CAP = 5'b00100,
        ST_WR_MERGE = 5'b01000,
        ST_WR_COMMIT = 5'b10000
    } table_state_e;

endpackage

// file: rtl/table_read_mapper.sv
`timescale 1ns/100ps
module table_read_mapper
    import table_access_pkg::*;
(
    input wire logic [table_access_pkg::WORD_W-1:0] prog_word_i, // word from array
    input wire logic high_i, // upper program byte space
    input wire logic byte_mode_i, // byte sized transfer
    input wire logic byte_sel_i, // low address bit
    output logic [table_access_pkg::DATA_W-1:0] data_o // mapped data
);
    import table_access_pkg::*;

    // steer program bits onto the data word; phantom byte is always zero
    always_comb begin
        data_o = 16'h0000;
        if (!high_i) begin
            if (!byte_mode_i) begin
                data_o = prog_word_i[15:0];
            end else if (byte_sel_i) begin
                data_o = {8'h00, prog_word_i[15:8]};
            end else begin
                data_o = {8'h00, prog_word_i[7:0]};
            end
        end else begin
            if (!byte_mode_i || !byte_sel_i) begin
                data_o = {8'h00, prog_word_i[23:16]};
            end
        end
    end

endmodule

// file: test/prog_array_model.sv
`timescale 1ns/100ps
// behavioural program array, answers one cycle after each read strobe
module prog_array_model (
    input wire logic clk_i, // core clock
    input wire logic rd_i, // read strobe
    input wire logic [23:0] addr_i, // target address
    output logic [23:0] rdata_o // word, valid one cycle only
);
    ////////////////////////////////////////////////////////////////////////
    // stale data is inverted each cycle so a late sample cannot match
    always @(posedge clk_i) begin
        if (rd_i === 1'b1) begin
            rdata_o <= {addr_i[7:0] ^ 8'hC3, addr_i[15:0] ^ {addr_i[23:16], 8'h5A}};
        end else begin
            rdata_o <= ~rdata_o;
        end
    end
endmodule

// file: test/program_space_table_access_tb_top.sv
`timescale 1ns/100ps
module program_space_table_access_tb_top;
    import table_access_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic we_i = 1'b0;
    logic [3:0] sel_i = 4'h0;
    logic [3:0] wsel = 4'hF;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic ack_o;
    logic run_mode_i = 1'b1;
    logic prog_rd_o;
    logic [23:0] prog_addr_o;
    logic [23:0] prog_rdata_i;
    logic cfg_space_o;
    logic busy_o;
    logic [5:0] hold_idx_i = 6'h08;
    logic [23:0] hold_data_o;
    logic [16:0] hold_row_o;
    logic [6:0] hold_count_o;
    logic hold_clear_i = 1'b0;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    int n_rd = 0;
    int bcnt = 0;
    int last_bcnt = 0;
    logic [23:0] rd_addr;
    logic [31:0] q;

    always #50 clk_i = ~clk_i;

    program_space_table_access u_program_space_table_access (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
        .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
        .run_mode_i(run_mode_i), .prog_rd_o(prog_rd_o), .prog_addr_o(prog_addr_o),
        .prog_rdata_i(prog_rdata_i), .cfg_space_o(cfg_space_o), .busy_o(busy_o),
        .hold_idx_i(hold_idx_i), .hold_data_o(hold_data_o), .hold_row_o(hold_row_o),
        .hold_count_o(hold_count_o), .hold_clear_i(hold_clear_i));

    prog_array_model u_prog_array_model (
        .clk_i(clk_i), .rd_i(prog_rd_o), .addr_i(prog_addr_o), .rdata_o(prog_rdata_i));

    ////////////////////////////////////////////////////////////////////////
    // strobe count, busy length and run ceiling
    always @(posedge clk_i) begin
        cycles++;
        if (prog_rd_o === 1'b1) begin
            n_rd++;
            rd_addr = prog_addr_o;
        end
        if (busy_o === 1'b1) begin
            bcnt++;
        end else if (bcnt != 0) begin
            last_bcnt = bcnt;
            bcnt = 0;
        end
        if (cycles == 20000) begin
            n_fail++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // same word pattern as the array model
    function automatic logic [23:0] pat(input logic [23:0] a);
        return {a[7:0] ^ 8'hC3, a[15:0] ^ {a[23:16], 8'h5A}};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one classic cycle; waits for ack, only the run ceiling ends a hang
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        sel_i <= wsel;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    // set pointer, start command, poll status until idle
    task automatic op(input logic [15:0] oa, input logic [3:0] cmd);
        wb(OFF_OPERAND_ADDR, 1'b1, {16'h0, oa});
        wb(OFF_CMD, 1'b1, {28'h0, cmd});
        do begin
            wb(OFF_STATUS, 1'b0, 32'h0);
        end while (q[STAT_BUSY_BIT] !== 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        wb(OFF_PAGE, 1'b0, 32'h0);
        chk("page_rst", 32'h0, q);
        wb(OFF_STATUS, 1'b0, 32'h0);
        chk("status_rst", 32'h0, q);
        wb(8'h14, 1'b1, 32'hFFFF);
        wb(8'h14, 1'b0, 32'h0);
        chk("unmapped", 32'h0, q);
        $display("test reset done");
    endtask

    // every space, size and byte select
    task automatic t_read_modes;
        logic [15:0] oa;
        logic [23:0] p;
        logic [15:0] e;
        wb(OFF_PAGE, 1'b1, 32'h12);
        for (int i = 0; i < 8; i++) begin
            oa = 16'h3456 | 16'(i[2]);
            p = pat({8'h12, oa});
            if (!i[0] && !i[1]) e = p[15:0];
            else if (!i[0]) e = {8'h00, i[2] ? p[15:8] : p[7:0]};
            else if (!i[1] || !i[2]) e = {8'h00, p[23:16]};
            else e = 16'h0000;
            op(oa, {1'b0, i[1], 1'b0, i[0]});
            wb(OFF_DATA, 1'b0, 32'h0);
            chk("read_data", {16'h0, e}, q);
            chk("read_addr", {8'h0, 8'h12, oa}, {8'h0, rd_addr});
        end
        $display("test read modes done");
    endtask

    task automatic t_increment;
        op(16'h0100, 4'b1000);
        wb(OFF_OPERAND_ADDR, 1'b0, 32'h0);
        chk("addr_word_step", 32'h0102, q);
        op(16'h0101, 4'b1100);
        wb(OFF_OPERAND_ADDR, 1'b0, 32'h0);
        chk("addr_byte_step", 32'h0102, q);
        $display("test increment done");
    endtask

    task automatic t_page_cfg;
        wb(OFF_PAGE, 1'b1, 32'h1FF);
        wb(OFF_PAGE, 1'b0, 32'h0);
        chk("page_width", 32'hFF, q);
        wb(OFF_PAGE, 1'b1, 32'h85);
        op(16'h0002, 4'b0000);
        chk("cfg_addr", {8'h0, 24'h850002}, {8'h0, rd_addr});
        chk("cfg_pin", 32'h1, {31'h0, cfg_space_o});
        chk("cfg_stat", 32'h1, {31'h0, q[2]});
        wb(OFF_PAGE, 1'b1, 32'h05);
        op(16'h0002, 4'b0000);
        chk("user_pin", 32'h0, {31'h0, cfg_space_o});
        $display("test page done");
    endtask

    // writes land only in the holding buffer, array never read
    task automatic t_write;
        int n0;
        n0 = n_rd;
        wb(OFF_PAGE, 1'b1, 32'h03);
        wb(OFF_DATA, 1'b1, 32'hBEEF);
        op(16'h0090, 4'b0010);
        chk("busy_len", 32'd2, last_bcnt);
        chk("count_low", 32'd1, {25'h0, hold_count_o});
        chk("buf_low", 32'hBEEF, {16'h0, hold_data_o[15:0]});
        chk("row", {15'h0, 8'h03, 9'h001}, {15'h0, hold_row_o});
        wb(OFF_DATA, 1'b1, 32'h1277);
        op(16'h0090, 4'b0011);
        wb(OFF_DATA, 1'b1, 32'h0055);
        op(16'h0091, 4'b0110);
        wb(OFF_DATA, 1'b1, 32'h0099);
        op(16'h0091, 4'b0111);
        chk("buf_word", 32'h7755EF, {8'h0, hold_data_o});
        chk("count_mix", 32'd2, {25'h0, hold_count_o});
        chk("no_array_rd", n0, n_rd);
        // a buffered write with post increment steps a whole word
        wb(OFF_DATA, 1'b1, 32'h0123);
        op(16'h0092, 4'b1010);
        wb(OFF_OPERAND_ADDR, 1'b0, 32'h0);
        chk("addr_wr_step", 32'h0094, q);
        @(posedge clk_i);
        hold_clear_i <= 1'b1;
        @(posedge clk_i);
        hold_clear_i <= 1'b0;
        @(posedge clk_i);
        @(posedge clk_i);
        chk("count_clr", 32'd0, {25'h0, hold_count_o});
        $display("test write done");
    endtask

    task automatic t_refuse;
        int n0;
        n0 = n_rd;
        run_mode_i <= 1'b0;
        op(16'h0004, 4'b0000);
        chk("halted_rd", n0, n_rd);
        chk("err_set", 32'h1, {31'h0, q[1]});
        run_mode_i <= 1'b1;
        wb(OFF_STATUS, 1'b1, 32'h2);
        wb(OFF_STATUS, 1'b0, 32'h0);
        chk("err_clr", 32'h0, {31'h0, q[1]});
        // command without its low byte lane is refused too
        wsel = 4'hE;
        wb(OFF_CMD, 1'b1, 32'h0);
        wsel = 4'hF;
        wb(OFF_STATUS, 1'b0, 32'h0);
        chk("lane_refused", 32'h1, {31'h0, q[1]});
        chk("lane_no_rd", n0, n_rd);
        $display("test refuse done");
    endtask

    task automatic results;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_read_modes();
        t_increment();
        t_page_cfg();
        t_write();
        t_refuse();
        results();
    end
endmodule
